// File: inc/smap_pkg.sv
// constants, types and helper functions of the switch memory access port
package smap_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_ADDR = 4'h1;
  localparam logic [3:0] OFS_DATA = 4'h2;
  localparam logic [3:0] OFS_STAT = 4'hC;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  localparam int CTRL_RWS_BIT = 7;
  localparam int ADDR_DIR_BIT = 7;
  localparam int STAT_PEND_BIT = 0;

  // ****************************************************************
  // operation encodings
  // ****************************************************************
  localparam logic [3:0] MOC_CM_DATA = 4'h9;
  localparam logic [3:0] MOC_TRI_ONE = 4'hC;
  localparam logic [3:0] MOC_TRI_ALL = 4'hD;
  localparam logic [3:0] CTRL_CODE_WR_HI = 4'h7;
  localparam logic [7:0] CTRL_CODE_RD = 8'hF0;
  localparam logic [2:0] CTRL_LOW_ZERO = 3'h0;

  // ****************************************************************
  // memory geometry and timing
  // ****************************************************************
  localparam int MEM_DEPTH = 128;
  localparam int CLK_PERIOD_NS = 8;
  localparam int ACCESS_TIME_NS = 16;
  localparam int ACCESS_CYC = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] ACCESS_CNT_LOAD = 4'(ACCESS_CYC - 2);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_EXEC = 3'b100
  } smap_state_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } smap_bus_req_type;

  typedef struct packed {
    logic       we;
    logic [6:0] idx;
    logic [7:0] data;
  } smap_hw_wr_type;

  typedef struct packed {
    logic       valid;
    logic       dir;
    logic [6:0] idx;
    logic [3:0] code;
    logic [7:0] data;
    logic [7:0] cfi_mask;
  } smap_cm_upd_type;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:0] smap_code_mask(input logic [3:0] code);
    case (code)
      4'h1:    smap_code_mask = 8'hFF;
      4'h3:    smap_code_mask = 8'hF0;
      4'h2:    smap_code_mask = 8'h0F;
      4'h7:    smap_code_mask = 8'hC0;
      4'h6:    smap_code_mask = 8'h30;
      4'h5:    smap_code_mask = 8'h0C;
      4'h4:    smap_code_mask = 8'h03;
      default: smap_code_mask = 8'h00;
    endcase
  endfunction : smap_code_mask

  function automatic logic [7:0] smap_cfi_mask(input logic [3:0] code, input logic [1:0] sc);
    smap_cfi_mask = 8'h00;
    if (code == 4'h1) begin
      smap_cfi_mask = 8'hFF;
    end else if (code[3:1] == 3'h1) begin
      smap_cfi_mask = sc[0] ? 8'h0F : 8'hF0;
    end else if (code[3:2] == 2'h1) begin
      case (sc)
        2'h0:    smap_cfi_mask = 8'hC0;
        2'h1:    smap_cfi_mask = 8'h30;
        2'h2:    smap_cfi_mask = 8'h0C;
        default: smap_cfi_mask = 8'h03;
      endcase
    end
  endfunction : smap_cfi_mask

endpackage : smap_pkg

// File: hw/smap_mem.sv
// flip-flop storage of 128 entries with one write port, a fill-all write and one read port
`timescale 1ns/10ps
module smap_mem #(
  parameter int W = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  input  wire logic         we,
  input  wire logic         wr_all,
  input  wire logic [6:0]   widx,
  input  wire logic [W-1:0] wdata,
  input  wire logic [6:0]   ridx,
  output logic [W-1:0]      rdata
);

  logic [W-1:0] mem_r   [smap_pkg::MEM_DEPTH];
  logic [W-1:0] mem_nxt [smap_pkg::MEM_DEPTH];

  always_comb begin
    mem_nxt = mem_r;
    if (wr_all) begin
      for (int i = 0; i < smap_pkg::MEM_DEPTH; i++) begin
        mem_nxt[i] = wdata;
      end
    end else if (we) begin
      mem_nxt[widx] = wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < smap_pkg::MEM_DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      mem_r <= mem_nxt;
    end
  end

  assign rdata = mem_r[ridx];

endmodule : smap_mem

// File: hw/smap_slot_split.sv
// splits a seven bit memory address into logical port and time slot
`timescale 1ns/10ps
module smap_slot_split (
  input  wire logic [1:0] mode,
  input  wire logic       is_cm,
  input  wire logic [6:0] ma,
  output logic [2:0]      port,
  output logic [6:0]      slot
);

  always_comb begin
    port = 3'h0;
    slot = ma;
    case (mode)
      2'h0: begin
        port = {1'b0, ma[2:1]};
        slot = {2'h0, ma[6:3], ma[0]};
      end
      2'h1: begin
        port = is_cm ? {2'h0, ma[1]} : {2'h0, ma[2]};
        slot = is_cm ? {1'b0, ma[6:3], ma[2], ma[0]} : {1'b0, ma[6:3], ma[1:0]};
      end
      2'h3: begin
        port = is_cm ? ma[3:1] : {2'h0, ma[2]};
        slot = is_cm ? {3'h0, ma[6:4], ma[0]} : {1'b0, ma[6:3], ma[1:0]};
      end
      default: begin
        port = 3'h0;
        slot = ma;
      end
    endcase
  end

endmodule : smap_slot_split

// File: hw/smap_access_port.sv
// indirect processor access port to connection and data memories
`timescale 1ns/10ps
module smap_access_port (
  input  wire logic                       ref_clk,
  input  wire logic                       sys_rst,
  input  wire smap_pkg::smap_bus_req_type bus_req,
  output logic [7:0]                      bus_rdata_r,
  input  wire logic [1:0]                 pcm_mode,
  input  wire logic [1:0]                 cfi_mode,
  input  wire logic [7:0]                 subchannel_select_reg,
  input  wire smap_pkg::smap_hw_wr_type   hw_dn_wr,
  output logic                            access_pending_flag,
  output logic [2:0]                      acc_port_r,
  output logic [6:0]                      acc_slot_r,
  output smap_pkg::smap_cm_upd_type       cm_upd_r
);

  // ****************************************************************
  // registers and state
  // ****************************************************************
  logic [7:0]                memory_op_control_r;
  logic [7:0]                memory_op_control_nxt;
  logic [7:0]                memory_op_address_r;
  logic [7:0]                memory_op_address_nxt;
  logic [7:0]                memory_op_data_r;
  logic [7:0]                memory_op_data_nxt;
  logic [7:0]                bus_rdata_nxt;
  logic                      pend_r;
  logic                      pend_nxt;
  logic [3:0]                cnt_r;
  logic [3:0]                cnt_nxt;
  smap_pkg::smap_state_type  state_r;
  smap_pkg::smap_state_type  state_nxt;
  logic [2:0]                acc_port_nxt;
  logic [6:0]                acc_slot_nxt;
  smap_pkg::smap_cm_upd_type cm_upd_nxt;

  // ****************************************************************
  // decode of the latched operation
  // ****************************************************************
  logic       read_write_select;
  logic [3:0] memory_operation_code;
  logic [3:0] slot_function_code;
  logic       low_zero;
  logic       dir_up;
  logic [6:0] slot_port_index;
  logic       op_code_wr;
  logic       op_code_rd;
  logic       op_cm_data;
  logic       op_tri_one;
  logic       op_tri_all;
  logic       op_dm_data;
  logic       exec;
  logic [7:0] dm_mask;

  assign read_write_select     = memory_op_control_r[smap_pkg::CTRL_RWS_BIT];
  assign memory_operation_code = memory_op_control_r[6:3];
  assign slot_function_code    = memory_op_control_r[3:0];
  assign low_zero              = memory_op_control_r[2:0] == smap_pkg::CTRL_LOW_ZERO;
  assign dir_up                = memory_op_address_r[smap_pkg::ADDR_DIR_BIT];
  assign slot_port_index       = memory_op_address_r[6:0];
  assign exec                  = state_r == smap_pkg::ST_EXEC;
  assign op_code_wr            = memory_op_control_r[7:4] == smap_pkg::CTRL_CODE_WR_HI;
  assign op_code_rd            = memory_op_control_r == smap_pkg::CTRL_CODE_RD;
  assign op_cm_data            = low_zero && memory_operation_code == smap_pkg::MOC_CM_DATA;
  assign op_tri_one            = low_zero && memory_operation_code == smap_pkg::MOC_TRI_ONE;
  assign op_tri_all            = low_zero && memory_operation_code == smap_pkg::MOC_TRI_ALL;
  assign dm_mask               = smap_pkg::smap_code_mask(memory_operation_code);
  assign op_dm_data            = low_zero && !op_code_wr && !op_code_rd && dm_mask != 8'h00;

  // ****************************************************************
  // memories
  // ****************************************************************
  logic        cm_we    [2];
  logic [11:0] cm_wdata;
  logic [11:0] cm_rdata [2];
  logic        dm_up_we;
  logic [7:0]  dm_up_wdata;
  logic [7:0]  dm_up_rdata;
  logic [7:0]  dm_dn_rdata;
  logic        tri_we;
  logic        tri_wall;
  logic [3:0]  tri_wdata;
  logic [3:0]  tri_rdata;
  logic [11:0] cm_sel;

  assign cm_sel = cm_rdata[dir_up];

  for (genvar d = 0; d < 2; d++) begin : g_cm
    smap_mem #(.W(12)) u_cm (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .we      (cm_we[d]),
      .wr_all  (1'b0),
      .widx    (slot_port_index),
      .wdata   (cm_wdata),
      .ridx    (slot_port_index),
      .rdata   (cm_rdata[d])
    );
  end

  smap_mem #(.W(8)) u_dm_up (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .we      (dm_up_we),
    .wr_all  (1'b0),
    .widx    (slot_port_index),
    .wdata   (dm_up_wdata),
    .ridx    (slot_port_index),
    .rdata   (dm_up_rdata)
  );

  smap_mem #(.W(8)) u_dm_dn (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .we      (hw_dn_wr.we),
    .wr_all  (1'b0),
    .widx    (hw_dn_wr.idx),
    .wdata   (hw_dn_wr.data),
    .ridx    (slot_port_index),
    .rdata   (dm_dn_rdata)
  );

  smap_mem #(.W(4)) u_tri (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .we      (tri_we),
    .wr_all  (tri_wall),
    .widx    (slot_port_index),
    .wdata   (tri_wdata),
    .ridx    (slot_port_index),
    .rdata   (tri_rdata)
  );

  logic [2:0] split_port;
  logic [6:0] split_slot;
  logic [1:0] split_mode;
  logic       split_is_cm;

  assign split_is_cm = op_code_wr || op_code_rd || op_cm_data;
  assign split_mode  = split_is_cm ? cfi_mode : pcm_mode;

  smap_slot_split u_split (
    .mode  (split_mode),
    .is_cm (split_is_cm),
    .ma    (slot_port_index),
    .port  (split_port),
    .slot  (split_slot)
  );

  // ****************************************************************
  // memory transfer
  // ****************************************************************
  always_comb begin
    cm_we[0]    = 1'b0;
    cm_we[1]    = 1'b0;
    cm_wdata    = cm_sel;
    dm_up_we    = 1'b0;
    dm_up_wdata = dm_up_rdata;
    tri_we      = 1'b0;
    tri_wall    = 1'b0;
    tri_wdata   = memory_op_data_r[3:0];
    if (exec && !read_write_select) begin
      if (op_code_wr) begin
        cm_we[dir_up] = 1'b1;
        cm_wdata      = {slot_function_code, memory_op_data_r};
      end else if (op_cm_data) begin
        cm_we[dir_up] = 1'b1;
        cm_wdata      = {cm_sel[11:8], memory_op_data_r};
      end else if (op_tri_one) begin
        tri_we = 1'b1;
      end else if (op_tri_all) begin
        tri_wall = 1'b1;
      end else if (op_dm_data && dir_up) begin
        dm_up_we    = 1'b1;
        dm_up_wdata = (dm_up_rdata & ~dm_mask) | (memory_op_data_r & dm_mask);
      end
    end
  end

  // ****************************************************************
  // register file, sequencer and read port
  // ****************************************************************
  always_comb begin
    memory_op_control_nxt = memory_op_control_r;
    memory_op_address_nxt = memory_op_address_r;
    memory_op_data_nxt    = memory_op_data_r;
    pend_nxt              = pend_r;
    cnt_nxt               = cnt_r;
    state_nxt             = state_r;
    acc_port_nxt          = acc_port_r;
    acc_slot_nxt          = acc_slot_r;
    cm_upd_nxt            = cm_upd_r;
    cm_upd_nxt.valid      = 1'b0;
    bus_rdata_nxt         = bus_rdata_r;
    if (bus_req.wr) begin
      case (bus_req.addr)
        smap_pkg::OFS_CTRL: begin
          if (!pend_r) begin
            memory_op_control_nxt = bus_req.wdata;
            pend_nxt              = 1'b1;
            cnt_nxt               = smap_pkg::ACCESS_CNT_LOAD;
            state_nxt             = smap_pkg::ST_WAIT;
          end
        end
        smap_pkg::OFS_ADDR: begin
          if (!pend_r) begin
            memory_op_address_nxt = bus_req.wdata;
          end
        end
        smap_pkg::OFS_DATA: begin
          memory_op_data_nxt = bus_req.wdata;
        end
        default: begin
        end
      endcase
    end
    if (bus_req.rd) begin
      case (bus_req.addr)
        smap_pkg::OFS_CTRL: bus_rdata_nxt = memory_op_control_r;
        smap_pkg::OFS_ADDR: bus_rdata_nxt = memory_op_address_r;
        smap_pkg::OFS_DATA: bus_rdata_nxt = memory_op_data_r;
        smap_pkg::OFS_STAT: bus_rdata_nxt = 8'(pend_r) << smap_pkg::STAT_PEND_BIT;
        default:            bus_rdata_nxt = 8'h00;
      endcase
    end
    case (state_r)
      smap_pkg::ST_IDLE: begin
      end
      smap_pkg::ST_WAIT: begin
        if (cnt_r == 4'h0) begin
          state_nxt = smap_pkg::ST_EXEC;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      smap_pkg::ST_EXEC: begin
        state_nxt    = smap_pkg::ST_IDLE;
        pend_nxt     = 1'b0;
        acc_port_nxt = split_port;
        acc_slot_nxt = split_slot;
        if (read_write_select) begin
          if (op_code_rd) begin
            memory_op_data_nxt = {4'h0, cm_sel[11:8]};
          end else if (op_cm_data) begin
            memory_op_data_nxt = cm_sel[7:0];
          end else if (op_tri_one) begin
            memory_op_data_nxt = {4'h0, tri_rdata};
          end else if (op_dm_data) begin
            memory_op_data_nxt = dir_up ? dm_up_rdata : dm_dn_rdata;
          end
        end else if (op_code_wr) begin
          cm_upd_nxt.valid = 1'b1;
          cm_upd_nxt.dir   = dir_up;
          cm_upd_nxt.idx   = slot_port_index;
          cm_upd_nxt.code  = slot_function_code;
          cm_upd_nxt.data  = memory_op_data_r;
          cm_upd_nxt.cfi_mask = smap_pkg::smap_cfi_mask(slot_function_code,
            subchannel_select_reg[{split_port[1:0], 1'b0} +: 2]);
        end
      end
      default: begin
        state_nxt = smap_pkg::ST_IDLE;
        pend_nxt  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      memory_op_control_r <= smap_pkg::CTRL_RST;
      memory_op_address_r <= smap_pkg::ADDR_RST;
      memory_op_data_r    <= smap_pkg::DATA_RST;
      pend_r              <= 1'b0;
      cnt_r               <= 4'h0;
      state_r             <= smap_pkg::ST_IDLE;
      acc_port_r          <= 3'h0;
      acc_slot_r          <= 7'h00;
      cm_upd_r            <= '0;
      bus_rdata_r         <= 8'h00;
    end else begin
      memory_op_control_r <= memory_op_control_nxt;
      memory_op_address_r <= memory_op_address_nxt;
      memory_op_data_r    <= memory_op_data_nxt;
      pend_r              <= pend_nxt;
      cnt_r               <= cnt_nxt;
      state_r             <= state_nxt;
      acc_port_r          <= acc_port_nxt;
      acc_slot_r          <= acc_slot_nxt;
      cm_upd_r            <= cm_upd_nxt;
      bus_rdata_r         <= bus_rdata_nxt;
    end
  end

  assign access_pending_flag = pend_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_start;
    bus_req.wr && bus_req.addr == smap_pkg::OFS_CTRL && !pend_r;
  endsequence

  sequence s_busy_then_done;
    access_pending_flag [*2] ##1 !access_pending_flag;
  endsequence

  a_pend_on_start: assert property (s_start |=> s_busy_then_done)
    else $error("pending flag does not span the access");
  a_pend_spacing: assert property ($rose(access_pending_flag) |-> s_busy_then_done)
    else $error("pending flag held for a wrong number of cycles");
  a_write_needs_rws: assert property ((dm_up_we || tri_we || tri_wall || cm_we[0] || cm_we[1])
                                      |-> exec && !memory_op_control_r[7])
    else $error("memory written on a read operation");
  a_dm_up_only: assert property (dm_up_we |-> memory_op_address_r[7] && op_dm_data)
    else $error("data memory write outside upstream field");
  a_dm_read_full: assert property (exec && read_write_select && op_dm_data
                                   |=> memory_op_data_r == $past(dir_up ? dm_up_rdata : dm_dn_rdata))
    else $error("data memory read lost bits");
  a_code_read_nib: assert property (exec && op_code_rd
                                    |=> memory_op_data_r == {4'h0, $past(cm_sel[11:8])})
    else $error("code read not in low nibble");
  a_tri_low_nib: assert property ((tri_we || tri_wall) |-> tri_wdata == memory_op_data_r[3:0])
    else $error("tristate value not from data low nibble");
  a_tri_all_fill: assert property (exec && !read_write_select && op_tri_all && !op_code_wr
                                   |-> tri_wall && !tri_we)
    else $error("fill-all tristate write missing");
  a_subch_merge: assert property (dm_up_we |-> ((dm_up_wdata ^ dm_up_rdata) & ~dm_mask) == 8'h00)
    else $error("subchannel write touched unselected bits");
  a_code_wr_upd: assert property (exec && op_code_wr && !read_write_select
                                  |=> cm_upd_r.valid && cm_upd_r.code == $past(slot_function_code)
                                      && cm_upd_r.data == $past(memory_op_data_r))
    else $error("code and data write not reported");

endmodule : smap_access_port

// File: sim/tb.sv
// self-checking testbench of the switch memory access port
`timescale 1ns/10ps
module tb;
  logic                       ref_clk     = 1'b0;
  logic                       sys_rst     = 1'b1;
  smap_pkg::smap_bus_req_type bus_req     = '0;
  logic [1:0]                 pcm_mode    = 2'h2;
  logic [1:0]                 cfi_mode    = 2'h0;
  logic [7:0]                 sc_reg      = 8'h00;
  smap_pkg::smap_hw_wr_type   hw_dn_wr    = '0;
  logic [7:0]                 bus_rdata_r;
  logic                       pend;
  logic [2:0]                 acc_port_r;
  logic [6:0]                 acc_slot_r;
  smap_pkg::smap_cm_upd_type  cm_upd_r;
  logic [7:0]                 r;
  int                         bad_count   = 0;
  int                         check_count = 0;

  smap_access_port dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata_r(bus_rdata_r),
    .pcm_mode(pcm_mode), .cfi_mode(cfi_mode), .subchannel_select_reg(sc_reg), .hw_dn_wr(hw_dn_wr),
    .access_pending_flag(pend), .acc_port_r(acc_port_r), .acc_slot_r(acc_slot_r), .cm_upd_r(cm_upd_r));

  always #4 ref_clk = ~ref_clk;

  // ****************************************************************
  // bus tasks, entered 1 ns after a rising edge
  // ****************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input logic w, input logic rd, input logic [3:0] a, input logic [7:0] d);
    bus_req = '{wr: w, rd: rd, addr: a, wdata: d};
    @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
    cyc(1'b0, 1'b1, a, 8'h00);
    d = bus_rdata_r;
  endtask : bus_rd

  // address, data, control, then poll pending and fetch data register
  task automatic op(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c, output logic [7:0] q);
    int n;
    cyc(1'b1, 1'b0, smap_pkg::OFS_ADDR, a);
    cyc(1'b1, 1'b0, smap_pkg::OFS_DATA, d);
    cyc(1'b1, 1'b0, smap_pkg::OFS_CTRL, c);
    cyc(1'b0, 1'b0, 4'h0, 8'h00);
    bus_rd(smap_pkg::OFS_STAT, q);
    chk(q, 8'h01);
    n = 0;
    while (q[0] !== 1'b0 && n < 20) begin
      bus_rd(smap_pkg::OFS_STAT, q);
      n++;
    end
    chk(q, 8'h00);
    bus_rd(smap_pkg::OFS_DATA, q);
    cyc(1'b0, 1'b0, 4'h0, 8'h00);
  endtask : op

  task automatic test_done;
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  initial begin
    #100000;
    bad_count++;
    test_done();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (10) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    bus_rd(smap_pkg::OFS_STAT, r); chk(r, 8'h00);
    bus_rd(4'h5, r);               chk(r, 8'h00);
    // data memory subchannel writes merge, reads return full byte
    op(8'h83, 8'h5A, 8'h08, r); op(8'h83, 8'h00, 8'h88, r); chk(r, 8'h5A);
    op(8'h83, 8'hC3, 8'h18, r); op(8'h83, 8'h00, 8'h88, r); chk(r, 8'hCA);
    op(8'h83, 8'h01, 8'h20, r); op(8'h83, 8'h00, 8'h88, r); chk(r, 8'hC9);
    op(8'h83, 8'hFF, 8'h00, r); op(8'h83, 8'h00, 8'h88, r); chk(r, 8'hC9);
    // downstream written only by the switching side
    op(8'h05, 8'hFF, 8'h08, r); op(8'h05, 8'h00, 8'h88, r); chk(r, 8'h00);
    hw_dn_wr = '{we: 1'b1, idx: 7'h05, data: 8'h77};
    @(posedge ref_clk);
    #1 hw_dn_wr = '0;
    op(8'h05, 8'h00, 8'h88, r); chk(r, 8'h77);
    // tristate field, single slot then all slots
    op(8'h83, 8'hAB, 8'h60, r); op(8'h83, 8'h00, 8'hE0, r); chk({4'h0, r[3:0]}, 8'h0B);
    op(8'h80, 8'h05, 8'h68, r); op(8'h89, 8'h00, 8'hE0, r); chk({4'h0, r[3:0]}, 8'h05);
    op(8'h83, 8'h00, 8'hE0, r); chk({4'h0, r[3:0]}, 8'h05);
    // connection memory code and data
    op(8'h82, 8'h33, 8'h79, r); chk({4'h0, cm_upd_r.code}, 8'h09);
    chk(cm_upd_r.data, 8'h33);
    op(8'h82, 8'h00, 8'hF0, r); chk(r, 8'h09);
    op(8'h82, 8'h00, 8'hC8, r); chk(r, 8'h33);
    op(8'h82, 8'h44, 8'h48, r); op(8'h82, 8'h00, 8'hC8, r); chk(r, 8'h44);
    op(8'h82, 8'h00, 8'hF0, r); chk(r, 8'h09);
    op(8'h04, 8'h00, 8'h7A, r); op(8'h04, 8'h00, 8'hF0, r); chk(r, 8'h0A);
    op(8'h85, 8'h00, 8'h7B, r); op(8'h85, 8'h00, 8'hF0, r); chk(r, 8'h0B);
    op(8'h02, 8'h00, 8'hF0, r); chk(r, 8'h00);
    // subchannel positions come from the select register
    sc_reg = 8'h01;
    op(8'h00, 8'h11, 8'h73, r); chk(cm_upd_r.cfi_mask, 8'h0F);
    sc_reg = 8'h00;
    op(8'h00, 8'h11, 8'h73, r); chk(cm_upd_r.cfi_mask, 8'hF0);
    op(8'h00, 8'h11, 8'h71, r); chk(cm_upd_r.cfi_mask, 8'hFF);
    // interface mode 3: port 3 from address bits 3..1 picks select bits 7..6
    cfi_mode = 2'h3;
    sc_reg = 8'h40;
    op(8'h06, 8'h11, 8'h73, r); chk(cm_upd_r.cfi_mask, 8'h0F);
    cfi_mode = 2'h0;
    sc_reg = 8'h00;
    // address split per highway mode
    op(8'h56, 8'h00, 8'h88, r); chk({1'b0, acc_slot_r}, 8'h56);
    pcm_mode = 2'h0;
    op(8'h56, 8'h00, 8'h88, r); chk({1'b0, acc_slot_r}, 8'h14);
    chk({5'h00, acc_port_r}, 8'h03);
    pcm_mode = 2'h1;
    op(8'h56, 8'h00, 8'h88, r); chk({1'b0, acc_slot_r}, 8'h2A);
    chk({5'h00, acc_port_r}, 8'h01);
    pcm_mode = 2'h3;
    op(8'h56, 8'h00, 8'h88, r); chk({1'b0, acc_slot_r}, 8'h2A);
    chk({5'h00, acc_port_r}, 8'h01);
    test_done();
  end
endmodule : tb
